// *** verilog/hbd_core.sv ***
// Half-bridge input logic with interlock, dead time and smart shutdown.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module hbd_core (
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire hbd_pkg::hbd_inputs_type pins,
  input  wire logic                    sense_above_ref,
  input  wire logic                    uvlo_low,
  input  wire hbd_pkg::hbd_line_type   line_level,
  input  wire hbd_pkg::hbd_bus_type    bus,
  output logic [hbd_pkg::DT_W-1:0]     rdata_q,
  output hbd_pkg::hbd_gates_type       gates_q,
  output logic                         fault_drain_out_q,
  output logic                         irq_q
);

  typedef enum logic [1:0] {HBD_RUN, HBD_PULL, HBD_WAIT} hbd_state_type;

  hbd_state_type            state_q;
  hbd_state_type            state_d;
  logic [1:0]               below_sync_q;
  logic [1:0]               above_sync_q;
  logic [hbd_pkg::DT_W-1:0] dead_time_q;
  logic [hbd_pkg::DT_W-1:0] dt_cnt_q;
  logic [hbd_pkg::DT_W-1:0] dt_cnt_d;
  logic [hbd_pkg::IRQ_W-1:0] irq_stat_q;
  logic [hbd_pkg::IRQ_W-1:0] irq_mask_q;
  logic [hbd_pkg::IRQ_W-1:0] irq_set;
  logic [hbd_pkg::IRQ_W-1:0] irq_clr;
  logic                     below_low;
  logic                     above_high;
  logic                     fault;
  logic                     want_low;
  logic                     want_high;
  logic                     turn_off;
  logic                     dt_busy;
  hbd_pkg::hbd_gates_type   gates_d;
  logic [hbd_pkg::DT_W-1:0] rdata_d;

  // Write decode shared by every writable register.
  function automatic logic reg_write(input hbd_pkg::hbd_bus_type b,
                                     input logic [1:0]          a);
    reg_write = b.wr && (b.addr == a);
  endfunction : reg_write

  // Synchronised thresholds of the shared line.
  assign below_low  = below_sync_q[1];
  assign above_high = above_sync_q[1];

  // The comparator is gated by undervoltage before anything else sees it.
  assign fault = sense_above_ref && !uvlo_low;

  // Requested gates from the truth table; shutdown is combinational, never stored.
  assign want_low  = pins.shutdown_n && !pins.low_side_in && !pins.high_side_in;
  assign want_high = pins.shutdown_n && pins.low_side_in && pins.high_side_in;

  // Either gate falling restarts the dead time counter.
  assign turn_off = (gates_q.low_gate_out && !gates_d.low_gate_out) ||
                    (gates_q.high_gate_out && !gates_d.high_gate_out);
  assign dt_busy  = (dt_cnt_q != hbd_pkg::DT_ZERO);

  // The fault term acts on the gates in the same cycle, not after the line falls.
  always_comb begin
    gates_d = '0;
    if (!fault && state_q == HBD_RUN) begin
      // A gate turns on only once the opposite gate is off, so a direct swap
      // of the inputs still loads the counter before the new gate may rise.
      gates_d.low_gate_out  = want_low && !gates_q.high_gate_out &&
                              (gates_q.low_gate_out || !dt_busy);
      gates_d.high_gate_out = want_high && !gates_q.low_gate_out &&
                              (gates_q.high_gate_out || !dt_busy);
    end
  end

  always_comb begin
    if (turn_off) begin
      dt_cnt_d = dead_time_q;
    end else if (dt_busy) begin
      dt_cnt_d = dt_cnt_q - hbd_pkg::DT_ONE;
    end else begin
      dt_cnt_d = dt_cnt_q;
    end
  end

  // Shutdown sequence: pull line, release below lower threshold, await upper.
  always_comb begin
    state_d = state_q;
    case (state_q)
      HBD_RUN: begin
        if (fault) begin
          state_d = HBD_PULL;
        end
      end
      HBD_PULL: begin
        if (below_low) begin
          state_d = HBD_WAIT;
        end
      end
      HBD_WAIT: begin
        if (fault) begin
          state_d = HBD_PULL;
        end else if (above_high) begin
          state_d = HBD_RUN;
        end
      end
      default: begin
        state_d = HBD_RUN;
      end
    endcase
  end

  assign irq_set[hbd_pkg::IRQ_FAULT]   = (state_q == HBD_RUN) && fault;
  assign irq_set[hbd_pkg::IRQ_RELEASE] = (state_q == HBD_WAIT) && (state_d == HBD_RUN);
  assign irq_clr = reg_write(bus, hbd_pkg::ADDR_IRQ) ?
                   bus.wdata[hbd_pkg::IRQ_W-1:0] : hbd_pkg::IRQ_NONE;

  always_comb begin
    rdata_d = '0;
    case (bus.addr)
      hbd_pkg::ADDR_CFG:    rdata_d = dead_time_q;
      hbd_pkg::ADDR_STATUS: rdata_d = {4'h0, fault_drain_out_q, gates_q, state_q == HBD_RUN};
      hbd_pkg::ADDR_IRQ:    rdata_d = {6'h00, irq_stat_q};
      hbd_pkg::ADDR_MASK:   rdata_d = {6'h00, irq_mask_q};
      default:              rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q           <= HBD_RUN;
      below_sync_q      <= '0;
      above_sync_q      <= '0;
      dead_time_q       <= hbd_pkg::DT_RESET;
      dt_cnt_q          <= hbd_pkg::DT_ZERO;
      gates_q           <= '0;
      fault_drain_out_q <= 1'b0;
      irq_stat_q        <= '0;
      irq_mask_q        <= '0;
      irq_q             <= 1'b0;
      rdata_q           <= '0;
    end else begin
      state_q           <= state_d;
      below_sync_q      <= {below_sync_q[0], line_level.below_low};
      above_sync_q      <= {above_sync_q[0], line_level.above_high};
      dt_cnt_q          <= dt_cnt_d;
      gates_q           <= gates_d;
      fault_drain_out_q <= (state_d == HBD_PULL);
      // A set in the same cycle as a clear wins.
      irq_stat_q        <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_q             <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
      rdata_q           <= bus.rd ? rdata_d : '0;
      if (reg_write(bus, hbd_pkg::ADDR_CFG)) begin
        dead_time_q <= bus.wdata;
      end
      if (reg_write(bus, hbd_pkg::ADDR_MASK)) begin
        irq_mask_q <= bus.wdata[hbd_pkg::IRQ_W-1:0];
      end
    end
  end

  // Assertions.
  shutdown_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !$past(pins.shutdown_n) |-> gates_q == '0)
    else $error("Gate on while shutdown low.");

  no_overlap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(gates_q.low_gate_out && gates_q.high_gate_out))
    else $error("Both gates on.");

  dead_time_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($fell(gates_q.low_gate_out) && dead_time_q != hbd_pkg::DT_ZERO) |=> !gates_q.high_gate_out)
    else $error("High gate on inside dead time.");

  dead_time_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($fell(gates_q.high_gate_out) && dead_time_q != hbd_pkg::DT_ZERO) |=> !gates_q.low_gate_out)
    else $error("Low gate on inside dead time.");

  dt_block_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    dt_busy |=> !$rose(gates_q.low_gate_out) && !$rose(gates_q.high_gate_out))
    else $error("Gate rose while dead time counted.");

  dt_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    turn_off |=> dt_cnt_q == $past(dead_time_q))
    else $error("Dead time counter not reloaded.");

  dt_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!turn_off && dt_busy) |=> dt_cnt_q == $past(dt_cnt_q) - hbd_pkg::DT_ONE)
    else $error("Dead time counter did not step.");

  cfg_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_write(bus, hbd_pkg::ADDR_CFG) |=> dead_time_q == $past(bus.wdata))
    else $error("Dead time write lost.");

  fault_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(fault) |-> gates_q == '0)
    else $error("Gate on after fault.");

  uvlo_mask_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == HBD_RUN && uvlo_low) |=> !fault_drain_out_q)
    else $error("Comparator acted in undervoltage.");

  sequence pull_start;
    state_q == HBD_RUN && fault;
  endsequence

  pull_on_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    pull_start |=> fault_drain_out_q)
    else $error("Drain not pulled on fault.");

  pull_release_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == HBD_PULL && below_low && !fault) |=> !fault_drain_out_q)
    else $error("Drain not released.");

  resume_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == HBD_WAIT && !above_high) |=> gates_q == '0)
    else $error("Gate resumed below upper threshold.");

  sequence resume_start;
    state_q == HBD_WAIT && above_high && !fault;
  endsequence

  resume_run_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    resume_start |=> state_q == HBD_RUN)
    else $error("No return to run above upper threshold.");

  release_irq_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    resume_start |=> irq_stat_q[hbd_pkg::IRQ_RELEASE])
    else $error("Release event not recorded.");

  fault_state_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    pull_start |=> state_q == HBD_PULL)
    else $error("Fault did not enter shutdown.");

  fault_irq_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    pull_start |=> irq_stat_q[hbd_pkg::IRQ_FAULT])
    else $error("Fault event not recorded.");

  drain_state_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    fault_drain_out_q == (state_q == HBD_PULL))
    else $error("Drain does not match shutdown state.");

  truth_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == HBD_RUN && !fault && want_low && !dt_busy && !gates_q.high_gate_out)
      |=> gates_q.low_gate_out)
    else $error("Low gate did not follow inputs.");

  truth_high_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == HBD_RUN && !fault && want_high && !dt_busy && !gates_q.low_gate_out)
      |=> gates_q.high_gate_out)
    else $error("High gate did not follow inputs.");

  invalid_in_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!want_low && !want_high) |=> gates_q == '0)
    else $error("Gate on for an off input pair.");

  uvlo_state_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == HBD_RUN && uvlo_low) |=> state_q == HBD_RUN)
    else $error("Shutdown entered in undervoltage.");

  sync_below_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(rstn, 2) |-> below_low == $past(line_level.below_low, 2))
    else $error("Lower threshold not two stages late.");

  sync_above_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(rstn, 2) |-> above_high == $past(line_level.above_high, 2))
    else $error("Upper threshold not two stages late.");

  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !bus.rd |=> rdata_q == '0)
    else $error("Read data without a read.");

  irq_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_write(bus, hbd_pkg::ADDR_IRQ) && bus.wdata[hbd_pkg::IRQ_FAULT] &&
     !irq_set[hbd_pkg::IRQ_FAULT]) |=> !irq_stat_q[hbd_pkg::IRQ_FAULT])
    else $error("Fault status not cleared.");

endmodule : hbd_core

// *** verilog/hbd_pkg.sv ***
// Package with constants and carrier types for the half-bridge input logic.
package hbd_pkg;

  localparam int          DT_W         = 8;
  localparam logic [7:0]  DT_RESET     = 8'h10;
  localparam logic [7:0]  DT_ZERO      = 8'h00;
  localparam logic [7:0]  DT_ONE       = 8'h01;
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_FAULT    = 0;
  localparam int          IRQ_RELEASE  = 1;
  localparam logic [1:0]  IRQ_NONE     = 2'h0;

  localparam logic [1:0]  ADDR_CFG     = 2'h0;
  localparam logic [1:0]  ADDR_STATUS  = 2'h1;
  localparam logic [1:0]  ADDR_IRQ     = 2'h2;
  localparam logic [1:0]  ADDR_MASK    = 2'h3;

  typedef struct packed {
    logic shutdown_n;
    logic low_side_in;
    logic high_side_in;
  } hbd_inputs_type;

  typedef struct packed {
    logic low_gate_out;
    logic high_gate_out;
  } hbd_gates_type;

  typedef struct packed {
    logic below_low;
    logic above_high;
  } hbd_line_type;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [1:0]           addr;
    logic [DT_W-1:0]      wdata;
  } hbd_bus_type;

endpackage : hbd_pkg

// *** verification/hbd_ctrl_model.sv ***
// Controller and shared shutdown line model with a slow pull-up.
`timescale 1ns/1ps

module hbd_ctrl_model (
  input  wire logic             clk_sys,
  input  wire logic             drain,
  input  wire logic             force_low,
  input  wire logic             latch_en,
  output logic                  line_q,
  output hbd_pkg::hbd_line_type level
);
  logic [2:0] volt_q = 3'h7;
  logic       latch_q = 1'b0;
  wire        pull = drain | force_low | latch_q;
  assign level = {volt_q < 3'h2, volt_q > 3'h5};
  initial line_q = 1'b1;
  // The pull-down wins at once while the pull-up climbs slowly, like an RC line.
  always @(posedge clk_sys) begin
    latch_q <= latch_en & (latch_q | drain);
    volt_q  <= pull ? 3'h0 : volt_q + {2'h0, volt_q != 3'h7};
    line_q  <= level.above_high | (line_q & !level.below_low);
  end
endmodule : hbd_ctrl_model

// *** verification/hbd_core_bench.sv ***
// Self-checking bench for the half-bridge input logic core.
`timescale 1ns/1ps

module hbd_core_bench;
  logic                   clk_sys = 1'b0;
  logic                   rstn = 1'b0;
  logic                   low_in = 1'b0, high_in = 1'b0, sense = 1'b0, uvlo = 1'b0;
  logic                   force_low = 1'b0, latch_en = 1'b0, line, drain, irq;
  logic [7:0]             rdata;
  logic [2:0]             b;
  hbd_pkg::hbd_bus_type   bus = '0;
  hbd_pkg::hbd_line_type  level;
  hbd_pkg::hbd_gates_type gates;
  int                     errors = 0, checked = 0, n;

  hbd_core i_hbd_core (.clk_sys(clk_sys), .rstn(rstn), .pins({line, low_in, high_in}),
    .sense_above_ref(sense), .uvlo_low(uvlo), .line_level(level), .bus(bus),
    .rdata_q(rdata), .gates_q(gates), .fault_drain_out_q(drain), .irq_q(irq));
  hbd_ctrl_model i_hbd_ctrl_model (.clk_sys(clk_sys), .drain(drain), .force_low(force_low),
    .latch_en(latch_en), .line_q(line), .level(level));

  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys) bus.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_chk
  // Every wait is bounded so a stuck design ends the run instead of hanging it.
  task automatic wait_gates(input logic [1:0] e);
    n = 0;
    while (gates !== e && n < 60) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check({6'h00, gates}, {6'h00, e});
    if (n >= 60) conclude();
  endtask : wait_gates

  initial forever #10 clk_sys = ~clk_sys;
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    #1 check({4'h0, irq, drain, gates}, 8'h00);
    rd_chk(hbd_pkg::ADDR_CFG, hbd_pkg::DT_RESET);
    rd_chk(hbd_pkg::ADDR_MASK, 8'h00);
    wr(hbd_pkg::ADDR_CFG, hbd_pkg::DT_ZERO);
    for (int i = 0; i < 8; i++) begin
      b = 3'(i);
      @(posedge clk_sys) force_low <= !b[2];
      low_in <= b[1];
      high_in <= b[0];
      repeat (14) @(posedge clk_sys);
      #1 check({6'h00, gates}, (b[2] && b[1] == b[0]) ? {6'h00, !b[1], b[1]} : 8'h00);
    end
    wr(hbd_pkg::ADDR_CFG, 8'h06);
    @(posedge clk_sys) low_in <= 1'b0;
    high_in <= 1'b0;
    n = 0;
    repeat (20) begin
      @(posedge clk_sys);
      #1 n += int'(gates === 2'h0);
    end
    check(8'(n >= 6 && n <= 8), 8'h01);
    check({6'h00, gates}, 8'h02);
    @(posedge clk_sys) low_in <= 1'b1;
    high_in <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge clk_sys);
      #1 n += int'(gates === 2'h0);
    end
    check(8'(n >= 6 && n <= 8), 8'h01);
    check({6'h00, gates}, 8'h01);
    @(posedge clk_sys) low_in <= 1'b0;
    high_in <= 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 check({6'h00, gates}, 8'h02);
    wr(hbd_pkg::ADDR_MASK, 8'h01);
    latch_en <= 1'b1;
    @(posedge clk_sys) sense <= 1'b1;
    @(posedge clk_sys) sense <= 1'b0;
    #1 check({5'h00, drain, gates}, 8'h04);
    @(posedge clk_sys) #1 check({7'h00, irq}, 8'h01);
    n = 0;
    while (drain !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check({7'h00, drain}, 8'h00);
    if (n >= 20) conclude();
    repeat (15) @(posedge clk_sys);
    #1 check({6'h00, gates}, 8'h00);
    latch_en <= 1'b0;
    wait_gates(2'h2);
    rd_chk(hbd_pkg::ADDR_STATUS, 8'h05);
    rd_chk(hbd_pkg::ADDR_IRQ, 8'h03);
    wr(hbd_pkg::ADDR_IRQ, 8'h03);
    repeat (2) @(posedge clk_sys);
    #1 check({7'h00, irq}, 8'h00);
    @(posedge clk_sys) uvlo <= 1'b1;
    sense <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 check({5'h00, drain, gates}, 8'h02);
    conclude();
  end
endmodule : hbd_core_bench
